// ---- rtl/tsr_pkg.sv ----
// Shared constants, types and states of the temperature sensor slave front end
package tsr_pkg;
  // Clock and time base
  localparam longint unsigned CLK_PERIOD_PS  = 64'd4000;
  localparam longint unsigned PS_PER_MS      = 64'd1000000000;
  localparam longint unsigned CONV_PERIOD_MS = 64'd500;
  localparam longint unsigned TOUT_MIN_MS    = 64'd25;
  localparam longint unsigned TOUT_MAX_MS    = 64'd48;
  // Conversion period, longest time, rounds down
  localparam int unsigned     CONV_CYCLES    = int'((CONV_PERIOD_MS * PS_PER_MS) / CLK_PERIOD_PS);
  // Bus timeout, least time, rounds up; stays well below the longest time
  localparam int unsigned     TOUT_CYCLES    = int'((TOUT_MIN_MS * PS_PER_MS + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);
  localparam int              CONV_CNT_W     = 27;
  localparam int              TOUT_CNT_W     = 24;

  // Addressing
  localparam int              ADDR_W         = 7;
  localparam int              STRAP_W        = 4;
  localparam int              STRAPS_MINIMAL = 4;
  localparam int              STRAPS_ALARM   = 3;

  // Pointer codes
  localparam logic [7:0]      PTR_TEMP       = 8'h00;
  localparam logic [7:0]      PTR_CFG        = 8'h01;
  localparam logic [7:0]      PTR_UPPER      = 8'h02;
  localparam logic [7:0]      PTR_LOWER      = 8'h03;
  localparam logic [7:0]      PTR_HYST       = 8'h04;

  // Configuration field positions and reset values
  localparam int              CFG_SHDN_POS   = 0;
  localparam int              CFG_FQEN_POS   = 3;
  localparam int              CFG_TODIS_POS  = 7;
  localparam logic [7:0]      CFG_RESET      = 8'h00;
  localparam logic [7:0]      PTR_RESET      = 8'h00;
  localparam logic [15:0]     TEMP_RESET     = 16'h0000;
  localparam logic [15:0]     UPPER_RESET    = 16'h0000;
  localparam logic [15:0]     LOWER_RESET    = 16'h0000;
  localparam logic [15:0]     HYST_RESET     = 16'h0000;

  // Temperature layout
  localparam int              TEMP_W         = 13;
  localparam int              TEMP_LSB_POS   = 3;
  localparam int              STATUS_W       = 2;

  localparam logic [3:0]      BIT_CNT_FULL   = 4'h8;

  typedef struct packed {
    logic timeout_dis;
    logic fault_q_en;
    logic shutdown;
  } tsr_cfg_s;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] hyst;
  } tsr_thr_s;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_CMD,
    ST_ACK_CMD,
    ST_WDATA,
    ST_ACK_WDATA,
    ST_TX,
    ST_TX_ACK,
    ST_SKIP
  } tsr_state_e;
endpackage

// ---- rtl/tsr_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module tsr_pin_sync
  import tsr_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // First stage feeds only the second
  always_comb begin
    level_nxt = (s2_r == s3_r) ? s2_r : level_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r    <= RESET_VAL;
      s2_r    <= RESET_VAL;
      s3_r    <= RESET_VAL;
      level_r <= RESET_VAL;
    end else begin
      s1_r    <= pin;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule

// ---- rtl/tsr_slave.sv ----
// Two-wire slave and register front end of the temperature sensor
`timescale 1ns/1ns
module tsr_slave
  import tsr_pkg::*;
#(
  parameter bit              ALARM_VARIANT = 1'b0,
  parameter logic [6:0]      BASE_ADDR     = 7'h40,
  parameter int unsigned     CONV_TICKS    = CONV_CYCLES,
  parameter int unsigned     TOUT_TICKS    = TOUT_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                scl,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  input  wire logic                addr_strap_bit0,
  input  wire logic                addr_strap_bit1,
  input  wire logic                addr_strap_bit2,
  input  wire logic                addr_strap_bit3,
  input  wire logic [TEMP_W-1:0]   adc_temp,
  input  wire logic [STATUS_W-1:0] alarm_status,
  output logic                     conv_done,
  output tsr_cfg_s                 cfg,
  output tsr_thr_s                 thresholds
);
  localparam int          STRAPS    = ALARM_VARIANT ? STRAPS_ALARM : STRAPS_MINIMAL;
  localparam logic [6:0]  STRAP_MSK = 7'((1 << STRAPS) - 1);
  localparam logic [7:0]  PTR_LAST  = ALARM_VARIANT ? PTR_HYST : PTR_CFG;

  // Link side: bits taken on the true clock rise, read from the core only while clock is low
  logic [7:0] link_sr_r;
  logic [7:0] link_sr_nxt;

  always_comb begin
    link_sr_nxt = {link_sr_r[6:0], sda_i};
  end

  always_ff @(posedge scl) begin
    link_sr_r <= link_sr_nxt;
  end

  logic scl_f;
  logic sda_f;

  tsr_pin_sync #(.RESET_VAL(1'b1)) u_sync_scl (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (scl),
    .level (scl_f)
  );

  tsr_pin_sync #(.RESET_VAL(1'b1)) u_sync_sda (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (sda_i),
    .level (sda_f)
  );

  tsr_state_e      state_r, state_nxt;
  logic            scl_q_r, sda_q_r;
  logic [3:0]      bit_cnt_r, bit_cnt_nxt;
  logic [7:0]      tx_sr_r, tx_sr_nxt;
  logic            oe_r, oe_nxt;
  logic            rd_r, rd_nxt;
  logic            lsb_r, lsb_nxt;
  logic [7:0]      ptr_r, ptr_nxt;
  logic [7:0]      cfg_r, cfg_nxt;
  logic [15:0]     temp_r, temp_nxt;
  tsr_thr_s        thr_r, thr_nxt;
  logic            hold_r, hold_nxt;
  logic [CONV_CNT_W-1:0] conv_cnt_r, conv_cnt_nxt;
  logic [TOUT_CNT_W-1:0] tout_cnt_r, tout_cnt_nxt;
  logic            done_r, done_nxt;
  logic [6:0]      my_addr_r, my_addr_nxt;
  logic            strap_ok_r;

  logic rise, fall, start_ev, stop_ev;
  logic [15:0] rd_word;
  logic [7:0]  rd_byte;
  logic        ptr_ok;

  assign rise     = scl_f & ~scl_q_r;
  assign fall     = ~scl_f & scl_q_r;
  assign start_ev = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign stop_ev  = scl_f & scl_q_r & ~sda_q_r & sda_f;
  assign ptr_ok   = (ptr_r <= PTR_LAST);

  // Read value of the selected register
  always_comb begin
    rd_word = 16'h0000;
    if (ptr_ok) begin
      unique case (ptr_r)
        PTR_TEMP:  rd_word = temp_r;
        PTR_CFG:   rd_word = {cfg_r, cfg_r};
        PTR_UPPER: rd_word = thr_r.upper;
        PTR_LOWER: rd_word = thr_r.lower;
        PTR_HYST:  rd_word = thr_r.hyst;
        default:   rd_word = 16'h0000;
      endcase
    end
    rd_byte = lsb_r ? rd_word[7:0] : rd_word[15:8];
  end

  // Bus protocol
  always_comb begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    tx_sr_nxt   = tx_sr_r;
    oe_nxt      = oe_r;
    rd_nxt      = rd_r;
    lsb_nxt     = lsb_r;
    ptr_nxt     = ptr_r;
    cfg_nxt     = cfg_r;
    thr_nxt     = thr_r;
    hold_nxt    = hold_r;
    tout_cnt_nxt = '0;
    if (start_ev) begin
      state_nxt   = ST_ADDR;
      bit_cnt_nxt = 4'h0;
      oe_nxt      = 1'b0;
    end else if (stop_ev) begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
      hold_nxt  = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_SKIP: begin
          oe_nxt = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (rise) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          if (fall && bit_cnt_r == BIT_CNT_FULL) begin
            bit_cnt_nxt = 4'h0;
            oe_nxt      = 1'b1;
            unique case (state_r)
              ST_ADDR: begin
                if (link_sr_r[7:1] == my_addr_r) begin
                  rd_nxt    = link_sr_r[0];
                  state_nxt = ST_ACK_ADDR;
                end else begin
                  oe_nxt    = 1'b0;
                  state_nxt = ST_SKIP;
                end
              end
              ST_CMD: begin
                ptr_nxt   = link_sr_r;
                lsb_nxt   = 1'b0;
                state_nxt = ST_ACK_CMD;
              end
              default: begin
                state_nxt = ST_ACK_WDATA;
                lsb_nxt   = ~lsb_r;
                if (ptr_ok) begin
                  unique case (ptr_r)
                    PTR_CFG:   cfg_nxt = link_sr_r;
                    PTR_UPPER: if (lsb_r) thr_nxt.upper[7:0] = link_sr_r; else thr_nxt.upper[15:8] = link_sr_r;
                    PTR_LOWER: if (lsb_r) thr_nxt.lower[7:0] = link_sr_r; else thr_nxt.lower[15:8] = link_sr_r;
                    PTR_HYST:  if (lsb_r) thr_nxt.hyst[7:0] = link_sr_r; else thr_nxt.hyst[15:8] = link_sr_r;
                    default:   cfg_nxt = cfg_r; // Temperature is read only
                  endcase
                end
              end
            endcase
          end
        end
        ST_ACK_ADDR, ST_ACK_CMD, ST_ACK_WDATA: begin
          if (fall) begin
            oe_nxt = 1'b0;
            if (state_r == ST_ACK_ADDR && rd_r) begin
              tx_sr_nxt   = rd_byte;
              oe_nxt      = ~rd_byte[7];
              bit_cnt_nxt = 4'h1;
              state_nxt   = ST_TX;
              if (ptr_r == PTR_TEMP) begin
                hold_nxt = 1'b1;
              end
            end else begin
              state_nxt = (state_r == ST_ACK_ADDR) ? ST_CMD : ST_WDATA;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (bit_cnt_r == BIT_CNT_FULL) begin
              oe_nxt    = 1'b0;
              lsb_nxt   = ~lsb_r;
              state_nxt = ST_TX_ACK;
            end else begin
              tx_sr_nxt   = {tx_sr_r[6:0], 1'b0};
              oe_nxt      = ~tx_sr_r[6];
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (rise) begin
            rd_nxt = ~sda_f;
          end
          if (fall) begin
            if (rd_r) begin
              tx_sr_nxt   = rd_byte;
              oe_nxt      = ~rd_byte[7];
              bit_cnt_nxt = 4'h1;
              state_nxt   = ST_TX;
            end else begin
              state_nxt = ST_SKIP;
            end
          end
        end
      endcase
      // Stalled clock low frees the bus
      if (state_r != ST_IDLE && !scl_f && !cfg_r[CFG_TODIS_POS]) begin
        tout_cnt_nxt = tout_cnt_r + TOUT_CNT_W'(1);
        if (tout_cnt_r >= TOUT_CNT_W'(TOUT_TICKS - 1)) begin
          state_nxt    = ST_IDLE;
          oe_nxt       = 1'b0;
          hold_nxt     = 1'b0;
          tout_cnt_nxt = '0;
        end
      end
    end
  end

  // Continuous conversion timebase; the ADC value is latched at each period end
  always_comb begin
    conv_cnt_nxt = conv_cnt_r + CONV_CNT_W'(1);
    temp_nxt     = temp_r;
    done_nxt     = 1'b0;
    if (cfg_r[CFG_SHDN_POS] || hold_r) begin
      conv_cnt_nxt = '0;
    end else if (conv_cnt_r >= CONV_CNT_W'(CONV_TICKS - 1)) begin
      conv_cnt_nxt = '0;
      done_nxt     = 1'b1;
      temp_nxt     = {adc_temp, 3'b000};
      if (ALARM_VARIANT) begin
        temp_nxt[STATUS_W-1:0] = alarm_status;
      end
    end
  end

  // Straps are static, caught once after reset release
  always_comb begin
    my_addr_nxt = (BASE_ADDR & ~STRAP_MSK) |
                  ({3'b000, addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0} & STRAP_MSK);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
      bit_cnt_r  <= 4'h0;
      tx_sr_r    <= 8'h00;
      oe_r       <= 1'b0;
      rd_r       <= 1'b0;
      lsb_r      <= 1'b0;
      ptr_r      <= PTR_RESET;
      cfg_r      <= CFG_RESET;
      temp_r     <= TEMP_RESET;
      thr_r      <= {UPPER_RESET, LOWER_RESET, HYST_RESET};
      hold_r     <= 1'b0;
      conv_cnt_r <= '0;
      tout_cnt_r <= '0;
      done_r     <= 1'b0;
      my_addr_r  <= 7'h00;
      strap_ok_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      scl_q_r    <= scl_f;
      sda_q_r    <= sda_f;
      bit_cnt_r  <= bit_cnt_nxt;
      tx_sr_r    <= tx_sr_nxt;
      oe_r       <= oe_nxt;
      rd_r       <= rd_nxt;
      lsb_r      <= lsb_nxt;
      ptr_r      <= ptr_nxt;
      cfg_r      <= cfg_nxt;
      temp_r     <= temp_nxt;
      thr_r      <= thr_nxt;
      hold_r     <= hold_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      tout_cnt_r <= tout_cnt_nxt;
      done_r     <= done_nxt;
      strap_ok_r <= 1'b1;
      if (!strap_ok_r) begin
        my_addr_r <= my_addr_nxt;
      end
    end
  end

  // Open drain: the line is only ever pulled low
  assign sda_o                  = 1'b0;
  assign sda_oe                 = oe_r;
  assign conv_done              = done_r;
  assign cfg.timeout_dis        = cfg_r[CFG_TODIS_POS];
  assign cfg.fault_q_en         = cfg_r[CFG_FQEN_POS];
  assign cfg.shutdown           = cfg_r[CFG_SHDN_POS];
  assign thresholds             = thr_r;
endmodule

// ---- bench/tsr_props.sv ----
// Port checks of the sensor slave
`timescale 1ns/1ns
module tsr_props
  import tsr_pkg::*;
#(
  parameter bit          ALARM_VARIANT = 1'b0,
  parameter int unsigned CONV_TICKS    = 200,
  parameter int unsigned TOUT_TICKS    = 2000
) (
  input wire logic     clk,
  input wire logic     rst_n,
  input wire logic     scl,
  input wire logic     sda_i,
  input wire logic     sda_o,
  input wire logic     sda_oe,
  input wire logic     conv_done,
  input wire tsr_cfg_s cfg,
  input wire tsr_thr_s thresholds
);
  logic        scl_r, sda_r, busy_r, scl_nxt, sda_nxt, busy_nxt;
  logic [31:0] gap_r, idle_r, low_r, gap_nxt, idle_nxt, low_nxt;
  // Raw lines, so bus framing here leads the slave by its synchroniser lag
  always_comb begin
    scl_nxt  = scl;
    sda_nxt  = sda_i;
    busy_nxt = busy_r;
    if (scl && scl_r && sda_r != sda_i) begin
      busy_nxt = !sda_i;
    end
    gap_nxt  = conv_done ? 32'h0 : gap_r + 32'h1;
    idle_nxt = (conv_done || busy_r || cfg.shutdown) ? 32'h0 : idle_r + 32'h1;
    low_nxt  = (!scl && sda_oe) ? low_r + 32'h1 : 32'h0;
    if (!rst_n) begin
      busy_nxt = 1'b0;
      gap_nxt  = 32'h0;
      idle_nxt = 32'h0;
      low_nxt  = 32'h0;
    end
  end
  always_ff @(posedge clk) begin
    scl_r  <= scl_nxt;
    sda_r  <= sda_nxt;
    busy_r <= busy_nxt;
    gap_r  <= gap_nxt;
    idle_r <= idle_nxt;
    low_r  <= low_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_scl_high;
    scl [*5];
  endsequence
  property p_oe_steady;
    s_scl_high |-> $stable(sda_oe);
  endproperty
  a_oe_steady_high: assert property (p_oe_steady)
    else $error("data drive moved with clock high");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl && !$past(scl))
    else $error("data drive began with clock high");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data driven high");
  a_cfg_clock_low: assert property (!$stable(cfg) |-> !scl)
    else $error("config moved with clock high");
  a_thr_minimal: assert property (!ALARM_VARIANT |-> thresholds == '0)
    else $error("thresholds in minimal part");
  a_reset_vals: assert property ($rose(rst_n) |-> !sda_oe && !conv_done && cfg == '0)
    else $error("reset values wrong");
  a_done_pulse: assert property (conv_done |=> !conv_done)
    else $error("done pulse too long");
  a_conv_spacing: assert property (conv_done |-> gap_r >= CONV_TICKS - 2)
    else $error("conversions too close");
  a_conv_bound: assert property (idle_r <= CONV_TICKS + 16)
    else $error("conversion overdue");
  a_tout_free: assert property (!cfg.timeout_dis |-> low_r <= TOUT_TICKS + 16)
    else $error("stalled bus not released");
  a_tout_early: assert property ($fell(sda_oe) && !scl |-> (low_r < 16) || (low_r >= TOUT_TICKS - 16))
    else $error("stall release too early");
endmodule
bind tsr_slave tsr_props #(
  .ALARM_VARIANT(ALARM_VARIANT),
  .CONV_TICKS   (CONV_TICKS),
  .TOUT_TICKS   (TOUT_TICKS)
) u_props (
  .clk       (clk),
  .rst_n     (rst_n),
  .scl       (scl),
  .sda_i     (sda_i),
  .sda_o     (sda_o),
  .sda_oe    (sda_oe),
  .conv_done (conv_done),
  .cfg       (cfg),
  .thresholds(thresholds)
);

// ---- bench/tsr_master.sv ----
// Two-wire bus master model at the far side of the slave
`timescale 1ns/1ns
module tsr_master (
  output logic     scl,
  output logic     sda_low,
  input wire logic sda_w
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // Odd first delay keeps the link out of phase with the core clock when a start begins on a clock edge
  task automatic start_c();
    #9 sda_low = 1'b0;
    #32 scl = 1'b1;
    #32 sda_low = 1'b1;
    #32 scl = 1'b0;
  endtask
  // MSB first; fewer than nine clocks leaves the clock stalled low
  task automatic xfer(input logic [7:0] tx, input logic m_ack, input int n,
                      output logic [7:0] rx, output logic ack);
    ack = 1'b0;
    rx  = 8'h00;
    for (int i = 0; i < n; i++) begin
      #8 sda_low = (i < 8) ? !tx[7-i] : m_ack;
      #24 scl = 1'b1;
      if (i < 8) begin
        rx[7-i] = sda_w;
      end else begin
        ack = !sda_w;
      end
      #32 scl = 1'b0;
    end
  endtask
  task automatic stop_c();
    #8 sda_low = 1'b1;
    #24 scl = 1'b1;
    #32 sda_low = 1'b0;
    #32;
  endtask
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench of the sensor slave
`timescale 1ns/1ns
module testbench;
  import tsr_pkg::*;
  localparam int unsigned CT    = 200;
  localparam int unsigned TT    = 2000;
  localparam logic [3:0]  STRAP = 4'hA;
  localparam logic [6:0]  BASE  = 7'h40;
  localparam logic [6:0]  DEV   = {BASE[6:4], STRAP};
  localparam logic [6:0]  DEV2  = {BASE[6:3], 3'b101};
  logic              clk, rst_n, scl, sda_low, sda_w, sda_o, sda_oe, conv_done;
  logic [TEMP_W-1:0] adc;
  tsr_cfg_s          cfg;
  tsr_thr_s          thr;
  int                err_total, checks, cycles, convs, conv_mark;
  logic              sda_o2, sda_oe2, conv_done2;
  logic [1:0]        alm;
  logic [6:0]        dev_sel;
  tsr_cfg_s          cfg2;
  tsr_thr_s          thr2;
  // Pull-up on the data wire
  assign sda_w = !(sda_low || (sda_oe && !sda_o) || (sda_oe2 && !sda_o2));
  tsr_slave #(.ALARM_VARIANT(1'b0), .BASE_ADDR(BASE), .CONV_TICKS(CT), .TOUT_TICKS(TT)) dut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_bit0(STRAP[0]), .addr_strap_bit1(STRAP[1]), .addr_strap_bit2(STRAP[2]),
    .addr_strap_bit3(STRAP[3]), .adc_temp(adc), .alarm_status(2'h0), .conv_done(conv_done),
    .cfg(cfg), .thresholds(thr));
  // Alarm variant on the same bus; strap bit3 is ignored there
  tsr_slave #(.ALARM_VARIANT(1'b1), .BASE_ADDR(BASE), .CONV_TICKS(CT), .TOUT_TICKS(TT)) dut_alarm (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_w), .sda_o(sda_o2), .sda_oe(sda_oe2),
    .addr_strap_bit0(1'b1), .addr_strap_bit1(1'b0), .addr_strap_bit2(1'b1),
    .addr_strap_bit3(1'b1), .adc_temp(adc), .alarm_status(alm), .conv_done(conv_done2),
    .cfg(cfg2), .thresholds(thr2));
  tsr_master u_m (.scl(scl), .sda_low(sda_low), .sda_w(sda_w));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (conv_done === 1'b1) begin
      convs++;
    end
    if (cycles == 30000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
    logic [7:0] rx;
    logic       a;
    u_m.start_c();
    u_m.xfer({dev_sel, 1'b0}, 1'b0, 9, rx, a);
    chk(16'(a), 16'h1, "addr ack");
    u_m.xfer(p, 1'b0, 9, rx, a);
    chk(16'(a), 16'h1, "cmd ack");
    for (int i = 0; i < n; i++) begin
      u_m.xfer(i == n - 1 ? d[7:0] : d[15:8], 1'b0, 9, rx, a);
      chk(16'(a), 16'h1, "data ack");
    end
    u_m.stop_c();
  endtask
  task automatic rd(input logic [7:0] p, input int n, output logic [15:0] v);
    logic [7:0] rx;
    logic       a;
    v = 16'h0000;
    u_m.start_c();
    u_m.xfer({dev_sel, 1'b0}, 1'b0, 9, rx, a);
    u_m.xfer(p, 1'b0, 9, rx, a);
    u_m.start_c();
    u_m.xfer({dev_sel, 1'b1}, 1'b0, 9, rx, a);
    chk(16'(a), 16'h1, "read addr ack");
    conv_mark = convs;
    for (int i = 0; i < n; i++) begin
      u_m.xfer(8'hFF, i < n - 1, 9, rx, a);
      v = {v[7:0], rx};
    end
    u_m.stop_c();
  endtask
  task automatic wait_conv(output int n);
    n = 0;
    while (conv_done !== 1'b1 && n < CT + 20) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_cfg();
    logic [15:0] v;
    wr(PTR_CFG, 16'h0089, 1);
    chk(16'(cfg), 16'h0007, "cfg bits set");
    wr(PTR_CFG, 16'h8908, 2);
    chk(16'(cfg), 16'h0002, "cfg word");
    rd(PTR_CFG, 1, v);
    chk(v, 16'h0008, "cfg read");
    $display("test cfg done");
  endtask
  task automatic t_temp();
    logic [TEMP_W-1:0] tv [2] = '{13'h0190, 13'h1E55};
    logic [15:0]       v;
    int                n;
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      adc = tv[k];
      wait_conv(n);
      rd(PTR_TEMP, 2, v);
      chk(v, {tv[k], 3'b000}, "temp word");
      chk(16'(convs - conv_mark), 16'h0000, "conv held");
      wait_conv(n);
      chk(16'(n < CT + 20), 16'h1, "conv resumes");
    end
    $display("test temp done");
  endtask
  task automatic t_addr();
    logic [7:0] rx;
    logic       a;
    for (int i = 0; i < 4; i++) begin
      u_m.start_c();
      u_m.xfer({DEV ^ (7'h01 << i), 1'b0}, 1'b0, 9, rx, a);
      chk(16'(a), 16'h0, "foreign addr");
      u_m.stop_c();
    end
    $display("test addr done");
  endtask
  task automatic t_alarm();
    logic [15:0] v;
    int          n;
    dev_sel = DEV2;
    wr(PTR_UPPER, 16'h4B10, 2);
    chk(thr2.upper, 16'h4B10, "upper word");
    wr(PTR_LOWER, 16'hF620, 2);
    chk(thr2.lower, 16'hF620, "lower word");
    wr(PTR_HYST, 16'h0180, 2);
    chk(thr2.hyst, 16'h0180, "hyst word");
    rd(PTR_UPPER, 2, v);
    chk(v, 16'h4B10, "upper read");
    @(negedge clk);
    adc = 13'h0A5C;
    alm = 2'h2;
    n = 0;
    while (conv_done2 !== 1'b1 && n < CT + 20) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n < CT + 20), 16'h1, "alarm conv");
    rd(PTR_TEMP, 2, v);
    chk(v, {13'h0A5C, 1'b0, 2'h2}, "alarm temp");
    dev_sel = DEV;
    wr(PTR_UPPER, 16'h4B10, 2);
    chk(thr.upper | thr.lower | thr.hyst, 16'h0000, "minimal thresholds");
    rd(PTR_UPPER, 1, v);
    chk(v, 16'h0000, "minimal upper read");
    $display("test alarm done");
  endtask
  task automatic t_tout();
    logic [7:0]  rx;
    logic        a;
    logic [15:0] v;
    int          n;
    u_m.start_c();
    u_m.xfer({DEV, 1'b0}, 1'b0, 8, rx, a);
    n = 0;
    while (sda_oe !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(16'(sda_oe), 16'h1, "ack held");
    n = 0;
    while (sda_oe === 1'b1 && n < TT + 40) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n > TT - 20 && n < TT + 20), 16'h1, "stall release");
    u_m.stop_c();
    rd(PTR_CFG, 1, v);
    chk(v, 16'h0008, "idle after stall");
    $display("test timeout done");
  endtask
  initial begin
    rst_n     = 1'b0;
    adc       = 13'h0000;
    err_total = 0;
    checks    = 0;
    cycles    = 0;
    convs     = 0;
    conv_mark = 0;
    alm       = 2'h0;
    dev_sel   = DEV;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(16'(cfg), 16'h0000, "cfg reset");
    chk(16'(cfg2), 16'h0000, "alarm cfg reset");
    t_cfg();
    t_temp();
    t_addr();
    t_alarm();
    t_tout();
    give_verdict();
  end
endmodule
